// ### include/ism_regs.vh
// constants of the serial memory slave: word fields, sizes and bit counts
`ifndef ISM_REGS_VH
`define ISM_REGS_VH

// ****************************************
// device address word fields
// ****************************************
`define ISM_TYPE_MSB 7
`define ISM_TYPE_LSB 4
`define ISM_SEL_MSB 3
`define ISM_SEL_LSB 1
`define ISM_RW_BIT 0
`define ISM_RW_WRITE 1'h0
`define ISM_RW_READ 1'h1

// ****************************************
// memory geometry
// ****************************************
`define ISM_ADDR_W 13
`define ISM_ADDR_HI_MSB 4
`define ISM_ADDR_RESET 13'h0000

// ****************************************
// byte framing
// ****************************************
`define ISM_BITS_PER_BYTE 4'h8
`define ISM_CNT_RESET 4'h0
`define ISM_ACK_LOW 1'h0

// ****************************************
// pin synchroniser
// ****************************************
`define ISM_SYNC_STAGES 3

`endif

// ### design/ism_pin_sync.v
// three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/100ps
`default_nettype none

module ism_pin_sync #(
    parameter WIDTH = 1
) (
    input wire CLK,
    input wire RST,
    input wire [WIDTH-1:0] PIN,
    input wire [WIDTH-1:0] INIT,
    output reg [WIDTH-1:0] LEVEL
);

    reg [WIDTH-1:0] stage1_reg;
    reg [WIDTH-1:0] stage2_reg;
    reg [WIDTH-1:0] stage3_reg;

    // ****************************************
    // filter per bit
    // ****************************************
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            always @(posedge CLK) begin
                if (RST) begin
                    // start from the idle level of the pin, so no false edge follows reset
                    stage1_reg[i] <= INIT[i];
                    stage2_reg[i] <= INIT[i];
                    stage3_reg[i] <= INIT[i];
                    LEVEL[i] <= INIT[i];
                end else begin
                    stage1_reg[i] <= PIN[i];
                    stage2_reg[i] <= stage1_reg[i];
                    stage3_reg[i] <= stage2_reg[i];
                    if (stage2_reg[i] == stage3_reg[i]) begin
                        LEVEL[i] <= stage3_reg[i];
                    end
                end
            end
        end
    endgenerate

endmodule // ism_pin_sync

`default_nettype wire

// ### design/ism_top.v
// two-wire serial memory slave: address decode, byte and page writes, reads
`timescale 1ns/100ps
`default_nettype none
`include "ism_regs.vh"

// How it works
// (R1) address word: type, chip select, direction
// (R2) take part only on matching type code
// (R3) chip select matches straps two, one, zero
// (R4) mismatch returns to standby, line released
// (R5) eighth bit zero writes, one reads
// (R6) matching address word acknowledged low
// (R7) write: two address bytes, high first, acked
// (R8) data in bytes, receiver drives ack
// (R9) master drives clock; direction picks data driver
// (R10) read: eight bits out, sample master ack
// (R11) never withhold ack for write in progress
// (R12) protect high discards writes, reads allowed
// (R13) open protect input counts as low
// (R14) single byte write sequence, all acknowledged
// (R15) master sends zeros in top address bits
// (R16) further bytes go to next address, wrap
// (R17) byte committed when its ack clock ends
// (R18) current read returns next address, wraps
// (R19) random read via repeated start, read word
// (R20) master nacks final byte then stops
// (R21) stop before ack abandons to standby
// (R22) thirteen-bit counter, steps every byte
// (R23) sample on clock rise, drive on fall

module ism_top #(
    parameter ADDR_W = `ISM_ADDR_W,
    parameter [3:0] DEVICE_TYPE = 4'h5 // arbitrary value
) (
    input wire CLK,
    input wire RST,
    input wire SCL,
    input wire SDA_IN,
    output reg SDA_OUT,
    output reg SDA_OE,
    input wire WP,
    input wire CHIP_SELECT_STRAP_0,
    input wire CHIP_SELECT_STRAP_1,
    input wire CHIP_SELECT_STRAP_2,
    output reg STANDBY,
    output reg WRITE_STROBE
);

    localparam DEPTH = 1 << ADDR_W;

    // ****************************************
    // states
    // ****************************************
    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_DEV = 3'h1;
    localparam [2:0] S_AHI = 3'h2;
    localparam [2:0] S_ALO = 3'h3;
    localparam [2:0] S_WR = 3'h4;
    localparam [2:0] S_RD = 3'h5;

    // ****************************************
    // storage and state
    // ****************************************
    reg [7:0] mem [0:DEPTH-1];
    reg [2:0] state_reg;
    reg [3:0] cnt_reg;
    reg ack_reg;
    reg mack_reg;
    reg [7:0] shift_reg;
    reg [7:0] addr_hi_reg;
    reg [ADDR_W-1:0] addr_reg;
    reg scl_d_reg;
    reg sda_d_reg;

    wire scl_f;
    wire sda_f;
    wire wp_f;
    wire [2:0] strap_f;
    wire [5:0] pin_level;
    wire scl_rise;
    wire scl_fall;
    wire start_det;
    wire stop_det;
    wire ack_end;
    wire [ADDR_W-1:0] addr_inc;
    wire [7:0] rd_byte_cur;
    wire [7:0] rd_byte_inc;

    // ****************************************
    // pin synchronisers
    // ****************************************
    ism_pin_sync #(
        .WIDTH(6)
    ) u_sync (
        .CLK(CLK),
        .RST(RST),
        .PIN({CHIP_SELECT_STRAP_2, CHIP_SELECT_STRAP_1, CHIP_SELECT_STRAP_0, WP, SDA_IN, SCL}),
        .INIT(6'h03), // (R13)
        .LEVEL(pin_level)
    );

    assign scl_f = pin_level[0];
    assign sda_f = pin_level[1];
    assign wp_f = pin_level[2];
    assign strap_f = pin_level[5:3];

    // ****************************************
    // bus events
    // ****************************************
    assign scl_rise = scl_f & ~scl_d_reg; // (R23)
    assign scl_fall = ~scl_f & scl_d_reg; // (R23)
    assign start_det = scl_f & scl_d_reg & sda_d_reg & ~sda_f;
    assign stop_det = scl_f & scl_d_reg & ~sda_d_reg & sda_f;
    // falling clock edge that closes an acknowledge clock
    assign ack_end = scl_fall & ack_reg;

    always @(posedge CLK) begin
        if (RST) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl_f;
            sda_d_reg <= sda_f;
        end
    end

    // ****************************************
    // address counter helpers
    // ****************************************
    assign addr_inc = addr_reg + {{(ADDR_W-1){1'b0}}, 1'b1}; // (R22)
    assign rd_byte_cur = mem[addr_reg];
    assign rd_byte_inc = mem[addr_inc];

    // match of the received address word
    function addr_word_match;
        input [7:0] word;
        input [3:0] dtype;
        input [2:0] straps;
        begin
            addr_word_match = (word[`ISM_TYPE_MSB:`ISM_TYPE_LSB] == dtype) && // (R2)
                (word[`ISM_SEL_MSB:`ISM_SEL_LSB] == straps); // (R3)
        end
    endfunction

    // ****************************************
    // memory commit
    // ****************************************
    always @(posedge CLK) begin
        if (!RST && ack_end && (state_reg == S_WR) && !wp_f) begin // (R12) (R17)
            mem[addr_reg] <= shift_reg;
        end
    end

    // ****************************************
    // protocol engine
    // ****************************************
    always @(posedge CLK) begin
        if (RST) begin
            state_reg <= S_IDLE;
            cnt_reg <= `ISM_CNT_RESET;
            ack_reg <= 1'b0;
            mack_reg <= 1'b1;
            shift_reg <= 8'h00;
            addr_hi_reg <= 8'h00;
            addr_reg <= `ISM_ADDR_RESET;
            SDA_OUT <= 1'b0;
            SDA_OE <= 1'b0;
            STANDBY <= 1'b1;
            WRITE_STROBE <= 1'b0;
        end else begin
            SDA_OUT <= 1'b0;
            STANDBY <= (state_reg == S_IDLE);
            WRITE_STROBE <= 1'b0;
            if (start_det) begin
                state_reg <= S_DEV; // (R1) (R19)
                cnt_reg <= `ISM_CNT_RESET;
                ack_reg <= 1'b0;
                SDA_OE <= 1'b0;
            end else if (stop_det) begin
                state_reg <= S_IDLE; // (R21)
                cnt_reg <= `ISM_CNT_RESET;
                ack_reg <= 1'b0;
                SDA_OE <= 1'b0;
            end else if (state_reg == S_IDLE) begin
                SDA_OE <= 1'b0; // (R4)
            end else if (scl_rise) begin
                if (!ack_reg) begin
                    if (cnt_reg != `ISM_BITS_PER_BYTE) begin
                        cnt_reg <= cnt_reg + 4'h1;
                        if (state_reg != S_RD) begin
                            shift_reg <= {shift_reg[6:0], sda_f}; // (R23)
                        end
                    end
                end else if (state_reg == S_RD) begin
                    mack_reg <= sda_f; // (R10)
                end
            end else if (scl_fall) begin
                if (!ack_reg && (cnt_reg == `ISM_BITS_PER_BYTE)) begin
                    // ninth clock begins
                    ack_reg <= 1'b1;
                    case (state_reg)
                        S_DEV: begin
                            if (addr_word_match(shift_reg, DEVICE_TYPE, strap_f)) begin
                                SDA_OE <= 1'b1; // (R6) (R11)
                            end else begin
                                state_reg <= S_IDLE; // (R4)
                                ack_reg <= 1'b0;
                                SDA_OE <= 1'b0;
                            end
                        end
                        S_AHI: begin
                            SDA_OE <= 1'b1; // (R7)
                        end
                        S_ALO: begin
                            SDA_OE <= 1'b1; // (R7)
                        end
                        S_WR: begin
                            SDA_OE <= 1'b1; // (R8) (R11) (R14)
                        end
                        S_RD: begin
                            SDA_OE <= 1'b0; // (R10)
                            mack_reg <= 1'b1;
                        end
                        default: begin
                            SDA_OE <= 1'b0;
                        end
                    endcase
                end else if (ack_reg) begin
                    // ninth clock ends
                    ack_reg <= 1'b0;
                    cnt_reg <= `ISM_CNT_RESET;
                    SDA_OE <= 1'b0;
                    case (state_reg)
                        S_DEV: begin
                            if (shift_reg[`ISM_RW_BIT] == `ISM_RW_READ) begin
                                state_reg <= S_RD; // (R5) (R18)
                                shift_reg <= rd_byte_cur;
                                SDA_OE <= ~rd_byte_cur[7]; // (R9) (R23)
                            end else begin
                                state_reg <= S_AHI; // (R5) (R7)
                            end
                        end
                        S_AHI: begin
                            addr_hi_reg <= shift_reg; // (R15)
                            state_reg <= S_ALO;
                        end
                        S_ALO: begin
                            addr_reg <= {addr_hi_reg[`ISM_ADDR_HI_MSB:0], shift_reg}; // (R19)
                            state_reg <= S_WR;
                        end
                        S_WR: begin
                            addr_reg <= addr_inc; // (R16) (R22)
                            WRITE_STROBE <= ~wp_f; // (R12) (R17)
                        end
                        S_RD: begin
                            addr_reg <= addr_inc; // (R18) (R22)
                            if (mack_reg == `ISM_ACK_LOW) begin
                                shift_reg <= rd_byte_inc; // (R10)
                                SDA_OE <= ~rd_byte_inc[7];
                            end else begin
                                state_reg <= S_IDLE; // (R20)
                            end
                        end
                        default: begin
                            state_reg <= S_IDLE;
                        end
                    endcase
                end else if (state_reg == S_RD) begin
                    shift_reg <= {shift_reg[6:0], 1'b0}; // (R10) (R23)
                    SDA_OE <= ~shift_reg[6];
                end else begin
                    SDA_OE <= 1'b0;
                end
            end
        end
    end

endmodule // ism_top

`default_nettype wire

// ### tb/ism_top_monitor.sv
// checker of the serial memory slave pin timing
`timescale 1ns/100ps
`default_nettype none

module ism_top_monitor (
    input wire logic CLK,
    input wire logic RST,
    input wire logic SCL,
    input wire logic SDA_OUT,
    input wire logic SDA_OE,
    input wire logic WP,
    input wire logic STANDBY,
    input wire logic WRITE_STROBE
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    // ****************************************
    // data line drive
    // ****************************************
    open_drain_a: assert property (SDA_OE |-> SDA_OUT == 1'b0)
        else $error("data line driven high");
    oe_timing_a: assert property ($changed(SDA_OE) |-> !$past(SCL, 3) &&
        ($past(SCL, 5) || $past(SCL, 6) || $past(SCL, 7) || $past(SCL, 8)))
        else $error("data drive not after clock fall");
    oe_scl_low_a: assert property ($changed(SDA_OE) |-> !SCL)
        else $error("data drive changed in clock high");
    oe_hold_a: assert property ($rose(SDA_OE) |=> SDA_OE [*8])
        else $error("data drive too short");
    standby_quiet_a: assert property (STANDBY && $past(STANDBY) |-> !SDA_OE)
        else $error("data driven in standby");
    // ****************************************
    // array commit
    // ****************************************
    strobe_pulse_a: assert property (WRITE_STROBE |=> !WRITE_STROBE)
        else $error("commit strobe longer than one cycle");
    wp_discard_a: assert property (WP [*6] |-> !WRITE_STROBE)
        else $error("commit while protected");
    strobe_scl_low_a: assert property (WRITE_STROBE |-> !SCL && !STANDBY)
        else $error("commit outside acknowledge end");
endmodule // ism_top_monitor

bind ism_top ism_top_monitor mon (.CLK(CLK), .RST(RST), .SCL(SCL), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
    .WP(WP), .STANDBY(STANDBY), .WRITE_STROBE(WRITE_STROBE));
`default_nettype wire

// ### tb/ism_master_model.sv
// two-wire bus master model driving clock and data
`timescale 1ns/100ps
`default_nettype none

module ism_master_model (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_oe,
    output logic [7:0] rx_byte,
    output logic rx_valid
);
    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
        rx_byte = 8'h00;
        rx_valid = 1'b0;
    end
    // ****************************************
    // bus phases of eight system clocks
    // ****************************************
    task automatic hold(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic start();
        sda_oe = 1'b0;
        hold(8);
        scl = 1'b1;
        hold(8);
        sda_oe = 1'b1;
        hold(8);
        scl = 1'b0;
    endtask
    task automatic stop();
        hold(2);
        sda_oe = 1'b1;
        hold(6);
        scl = 1'b1;
        hold(8);
        sda_oe = 1'b0;
        hold(8);
    endtask
    task automatic xfer(input logic b, output logic r);
        hold(2);
        sda_oe = ~b;
        hold(6);
        scl = 1'b1;
        hold(8);
        r = sda;
        scl = 1'b0;
    endtask
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) xfer(d[i], r);
        xfer(1'b1, ack);
    endtask
    task automatic recv(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer(1'b1, r);
            d[i] = r;
        end
        xfer(nack, r);
        rx_byte = d;
        rx_valid = 1'b1;
        hold(1);
        rx_valid = 1'b0;
    endtask
endmodule // ism_master_model
`default_nettype wire

// ### tb/ism_top_bench.sv
// self-checking bench of the serial memory slave
`timescale 1ns/100ps
`default_nettype none

module ism_top_bench;
    localparam logic [3:0] TYPE = 4'h6; // arbitrary value
    localparam logic [2:0] SEL = 3'h5;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wp = 1'b0;
    logic scl, m_oe, sda_out, sda_oe, standby, strobe, rx_valid;
    logic [7:0] rx_byte;
    logic [7:0] mem [4];
    logic [7:0] exp_q [$];
    logic [31:0] seed = 32'h90E2;
    int fails = 0;
    int compares = 0;
    int strobes = 0;
    wire sda = ~(m_oe | sda_oe);
    always #5 clk = ~clk;
    ism_master_model m (.clk(clk), .sda(sda), .scl(scl), .sda_oe(m_oe), .rx_byte(rx_byte), .rx_valid(rx_valid));
    ism_top #(.DEVICE_TYPE(TYPE)) dut (.CLK(clk), .RST(rst), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
        .SDA_OE(sda_oe), .WP(wp), .CHIP_SELECT_STRAP_0(SEL[0]), .CHIP_SELECT_STRAP_1(SEL[1]),
        .CHIP_SELECT_STRAP_2(SEL[2]), .STANDBY(standby), .WRITE_STROBE(strobe));
    // ****************************************
    // checks and transfers
    // ****************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
    endfunction
    task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, e, g);
        end
    endtask
    task automatic results();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic word(input logic [7:0] w, input logic nak);
        logic a;
        m.start();
        m.send(w, a);
        check("word ack", {7'h00, nak}, {7'h00, a});
    endtask
    task automatic put(input logic [7:0] d);
        logic a;
        m.send(d, a);
        check("byte ack", 8'h00, {7'h00, a});
    endtask
    task automatic point(input logic [12:0] a);
        word({TYPE, SEL, 1'b0}, 1'b0);
        put({3'h0, a[12:8]});
        put(a[7:0]);
    endtask
    task automatic get(input logic [7:0] e, input logic nak);
        logic [7:0] d;
        exp_q.push_back(e);
        m.recv(nak, d);
    endtask
    always @(posedge clk) begin
        if (rx_valid)
            check("read byte", exp_q.pop_front(), rx_byte);
    end
    always @(posedge clk) begin
        if (strobe === 1'b1)
            strobes++;
    end
    initial begin
        repeat (100000) @(posedge clk);
        fails++;
        results();
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        repeat (6) @(negedge clk);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            mem[i] = seed[7:0];
        end
        point(13'h1FFE);
        for (int i = 0; i < 4; i++) put(mem[i]);
        m.stop();
        point(13'h1FFE);
        word({TYPE, SEL, 1'b1}, 1'b0);
        get(mem[0], 1'b0);
        get(mem[1], 1'b0);
        get(mem[2], 1'b1);
        m.stop();
        word({TYPE, SEL, 1'b1}, 1'b0);
        get(mem[3], 1'b1);
        m.stop();
        wp = 1'b1;
        point(13'h1FFE);
        put(~mem[0]);
        m.stop();
        wp = 1'b0;
        point(13'h1FFE);
        word({TYPE, SEL, 1'b1}, 1'b0);
        get(mem[0], 1'b1);
        m.stop();
        for (int b = 1; b < 8; b++) begin
            word({TYPE, SEL, 1'b0} ^ (8'h01 << b), 1'b1);
            m.stop();
        end
        check("pending reads", 8'h00, 8'(exp_q.size()));
        check("commit count", 8'h04, 8'(strobes));
        results();
    end
endmodule // ism_top_bench
`default_nettype wire
